// ---- core/probe_readout_pkg.sv ----
// constants and types shared by the probe resistance readout
package probe_readout_pkg;

   localparam int VOLT_W = 24;
   localparam int DATA_W = 32;
   localparam int CODE_W = 4;

   // connection codes, two's complement
   localparam logic signed [CODE_W-1:0] CODE_TWO_WIRE  = 4'h1;
   localparam logic signed [CODE_W-1:0] CODE_THREE_HI  = 4'h2;
   localparam logic signed [CODE_W-1:0] CODE_THREE_LO  = 4'h3;
   localparam logic signed [CODE_W-1:0] CODE_FOUR_WIRE = 4'h4;
   localparam logic signed [CODE_W-1:0] CODE_ADC_FAIL  = 4'hF;
   localparam logic signed [CODE_W-1:0] CODE_NEG_VOLT  = 4'hE;
   localparam logic signed [CODE_W-1:0] CODE_NO_PROBE  = 4'hD;
   localparam logic signed [CODE_W-1:0] CODE_SWAPPED   = 4'hC;
   localparam logic signed [CODE_W-1:0] CODE_NEG_OHMS  = 4'hB;

   // probe curve, figures as printed
   localparam real R0_OHM      = 100.0;
   localparam real CVD_A       = 3.9083e-3;
   localparam real CVD_B       = -5.775e-7;
   localparam real CVD_C       = -4.183e-12;
   localparam real LEAD_2W_OHM = 0.25;
   localparam real T_MIN_C     = -200.0;
   localparam real C_KNEE_C    = 100.0;
   localparam real SENTINEL    = -1000.0;

   // fixed point: resistance in milliohm, temperature in 1/256 degC
   localparam int T_FRAC    = 8;
   localparam int GAIN_FRAC = 16;
   localparam int R_FRAC    = 16;
   localparam int C_SHIFT   = 40;
   localparam int C_T_DROP  = 4;
   localparam int SAR_BITS  = 18;
   localparam real MOHM_PER_OHM = 1000.0;

   localparam longint R0_Q16  = longint'(R0_OHM * MOHM_PER_OHM * 65536.0);
   localparam longint KA      = longint'(R0_OHM * MOHM_PER_OHM * CVD_A
                                         * 256.0);
   localparam longint KB      = longint'(R0_OHM * MOHM_PER_OHM * CVD_B
                                         * 65536.0);
   localparam longint KC      = longint'(R0_OHM * MOHM_PER_OHM * CVD_C
                                         * 1099511627776.0);
   localparam longint C_KNEE_Q4 = longint'(C_KNEE_C * 16.0);
   localparam logic signed [DATA_W-1:0] LEAD_2W_MOHM =
      DATA_W'(longint'(LEAD_2W_OHM * MOHM_PER_OHM));
   localparam logic signed [DATA_W-1:0] T_MIN_Q =
      DATA_W'(longint'(T_MIN_C * 256.0));
   localparam logic signed [DATA_W-1:0] SENTINEL_OHMS =
      DATA_W'(longint'(SENTINEL * MOHM_PER_OHM));
   localparam logic signed [DATA_W-1:0] SENTINEL_CELSIUS =
      DATA_W'(longint'(SENTINEL * 256.0));

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_CLASSIFY,
      PH_SOLVE,
      PH_TRIM
   } phase_t;

endpackage : probe_readout_pkg

// ---- core/resistance_thermometer_readout.sv ----
// probe wiring detection, lead compensation and temperature solver
// How it works
// (R01) good codes: 1 two-wire, 2 upper sense, 3 lower sense, 4 four-wire
// (R02) faults: -1 converter, -2 negative volt, -3 none, -4 swap, -5 neg ohms
// (R03) temperature is solved only while the code is positive
// (R04) fault status output is high whenever the code is negative
// (R05) a converter sample of all four terminals taken while idle reclassifies the wiring; samples arriving while busy are dropped
// (R06) two-wire subtracts 0.25 ohm for each of the two leads
// (R07) three-wire measures the sensed lead, assumes the other one equal
// (R08) four-wire reads the element between both sense leads directly
// (R09) excitation terminal left floating high reports no probe
// (R10) a sense lead nearer the opposite excitation terminal reports swap
// (R11) a computed resistance below zero reports negative resistance
// (R12) ohms answer is latest resistance, or -1000.0 ohm on a fault
// (R13) celsius answer is latest temperature, or -1000.0 degC on a fault
// (R14) temperature found by inverting the platinum curve, C only below zero
// (R15) final temperature is gain trim times solved value plus offset
// (R16) host sets gain 1.0 and offset 0.0 to pass temperature unchanged
// (R17) code, ohms and celsius are committed together in one cycle
`timescale 1ns/1ps

module resistance_thermometer_readout
   import probe_readout_pkg::*;
#(
   parameter logic signed [VOLT_W-1:0] OPEN_LEVEL = 24'h7F0000
) (
   input  wire logic                     mclk,
   input  wire logic                     rst_b,
   input  wire logic                     sample_valid,
   input  wire logic                     adc_fault,
   input  wire logic signed [VOLT_W-1:0] excitation_high_terminal_v,
   input  wire logic signed [VOLT_W-1:0] sense_high_terminal_v,
   input  wire logic signed [VOLT_W-1:0] sense_low_terminal_v,
   input  wire logic signed [VOLT_W-1:0] excitation_low_terminal_v,
   input  wire logic signed [DATA_W-1:0] temperature_gain_trim,
   input  wire logic signed [DATA_W-1:0] temperature_offset_trim,
   input  wire logic                     probe_connection_query,
   input  wire logic                     probe_ohms_query,
   input  wire logic                     probe_celsius_query,
   output logic signed [CODE_W-1:0]      connection_code,
   output logic signed [DATA_W-1:0]      probe_ohms,
   output logic signed [DATA_W-1:0]      probe_celsius,
   output logic                          probe_fault_status,
   output logic                          answer_valid,
   output logic signed [DATA_W-1:0]      answer_data
);

   typedef struct packed {
      phase_t                    phase;
      logic                      adc_err;
      logic signed [VOLT_W-1:0]  v_hi;
      logic signed [VOLT_W-1:0]  v_sh;
      logic signed [VOLT_W-1:0]  v_sl;
      logic signed [VOLT_W-1:0]  v_lo;
      logic signed [CODE_W-1:0]  work_code;
      logic signed [DATA_W-1:0]  work_mohm;
      logic [SAR_BITS-1:0]       sar;
      logic [4:0]                bit_idx;
      logic signed [CODE_W-1:0]  code;
      logic signed [DATA_W-1:0]  ohms;
      logic signed [DATA_W-1:0]  celsius;
      logic                      ans_valid;
      logic signed [DATA_W-1:0]  ans_data;
   } state_t;

   state_t st_ff;
   state_t nxt_st;

   // forward curve: resistance in milliohm, 16 fraction bits
   function automatic logic signed [63:0] curve_mohm_q16(
      input logic signed [DATA_W-1:0] tq);
      logic signed [63:0] t;
      logic signed [63:0] t4;
      logic signed [63:0] p;
      logic signed [63:0] acc;
      logic signed [95:0] pc;
      t   = 64'(tq);
      // square term carries 16 extra fraction bits, drop them
      acc = R0_Q16 + KA * t + ((KB * t * t) >>> R_FRAC);
      t4  = t >>> C_T_DROP;
      p   = (t4 - C_KNEE_Q4) * t4 * t4 * t4;
      pc  = 96'(p) * 96'(KC);
      if (tq < 0) begin
         acc = acc + 64'(pc >>> C_SHIFT); // [R14]
      end
      return acc;
   endfunction : curve_mohm_q16

   function automatic logic signed [DATA_W-1:0] wid(
      input logic signed [VOLT_W-1:0] v);
      return DATA_W'(v);
   endfunction : wid

   logic                     sh_con;
   logic                     sl_con;
   logic signed [DATA_W-1:0] d_hi_sh;
   logic signed [DATA_W-1:0] d_sh_lo;
   logic signed [DATA_W-1:0] d_hi_sl;
   logic signed [DATA_W-1:0] d_sl_lo;
   logic signed [DATA_W-1:0] d_sh_sl;
   logic signed [DATA_W-1:0] d_hi_lo;
   logic signed [CODE_W-1:0] cls_code;
   logic signed [DATA_W-1:0] cls_mohm;
   logic [SAR_BITS-1:0]      trial;
   logic signed [DATA_W-1:0] trial_t;
   logic signed [DATA_W-1:0] solved_t;
   logic signed [63:0]       trimmed;

   always_comb begin
      sh_con  = st_ff.v_sh < OPEN_LEVEL;
      sl_con  = st_ff.v_sl < OPEN_LEVEL;
      d_hi_sh = wid(st_ff.v_hi) - wid(st_ff.v_sh);
      d_sh_lo = wid(st_ff.v_sh) - wid(st_ff.v_lo);
      d_hi_sl = wid(st_ff.v_hi) - wid(st_ff.v_sl);
      d_sl_lo = wid(st_ff.v_sl) - wid(st_ff.v_lo);
      d_sh_sl = wid(st_ff.v_sh) - wid(st_ff.v_sl);
      d_hi_lo = wid(st_ff.v_hi) - wid(st_ff.v_lo);
      // scheme and lead compensation
      if (sh_con && sl_con) begin
         cls_code = CODE_FOUR_WIRE;                     // [R01]
         cls_mohm = d_sh_sl;                            // [R08]
      end else if (sh_con) begin
         cls_code = CODE_THREE_HI;                      // [R01]
         cls_mohm = d_sh_lo - d_hi_sh;                  // [R07]
      end else if (sl_con) begin
         cls_code = CODE_THREE_LO;                      // [R01]
         cls_mohm = d_hi_sl - d_sl_lo;                  // [R07]
      end else begin
         cls_code = CODE_TWO_WIRE;                      // [R01]
         cls_mohm = d_hi_lo - (LEAD_2W_MOHM <<< 1);     // [R06]
      end
      // faults in priority order, last assignment wins
      if (cls_mohm < 0) begin
         cls_code = CODE_NEG_OHMS;                      // [R11]
      end
      if ((sh_con && d_sh_lo < d_hi_sh) ||
          (sl_con && d_hi_sl < d_sl_lo)) begin
         cls_code = CODE_SWAPPED;                       // [R10]
      end
      if (st_ff.v_hi >= OPEN_LEVEL) begin
         cls_code = CODE_NO_PROBE;                      // [R09]
      end
      if (st_ff.v_hi < 0 || st_ff.v_sh < 0 ||
          st_ff.v_sl < 0 || st_ff.v_lo < 0) begin
         cls_code = CODE_NEG_VOLT;                      // [R02]
      end
      if (st_ff.adc_err) begin
         cls_code = CODE_ADC_FAIL;                      // [R02]
      end
   end

   always_comb begin
      trial    = st_ff.sar | (SAR_BITS'(1) << st_ff.bit_idx);
      trial_t  = T_MIN_Q + DATA_W'(trial);
      solved_t = T_MIN_Q + DATA_W'(st_ff.sar);
      trimmed  = ((64'(temperature_gain_trim) * 64'(solved_t))
                  >>> GAIN_FRAC) + 64'(temperature_offset_trim); // [R15]
   end

   always_comb begin
      nxt_st           = st_ff;
      nxt_st.ans_valid = 1'b0;
      unique case (st_ff.phase)
         PH_IDLE: begin
            if (sample_valid) begin                     // [R05]
               nxt_st.adc_err = adc_fault;
               nxt_st.v_hi    = excitation_high_terminal_v;
               nxt_st.v_sh    = sense_high_terminal_v;
               nxt_st.v_sl    = sense_low_terminal_v;
               nxt_st.v_lo    = excitation_low_terminal_v;
               nxt_st.phase   = PH_CLASSIFY;
            end
         end
         PH_CLASSIFY: begin
            nxt_st.work_code = cls_code;
            nxt_st.work_mohm = cls_mohm;
            nxt_st.sar       = '0;
            nxt_st.bit_idx   = 5'(SAR_BITS - 1);
            if (cls_code > 0) begin
               nxt_st.phase = PH_SOLVE;                 // [R03]
            end else begin
               nxt_st.code    = cls_code;               // [R17]
               nxt_st.ohms    = SENTINEL_OHMS;          // [R12]
               nxt_st.celsius = SENTINEL_CELSIUS;       // [R13]
               nxt_st.phase   = PH_IDLE;
            end
         end
         PH_SOLVE: begin
            // successive approximation on a rising curve
            if (curve_mohm_q16(trial_t) <=
                (64'(st_ff.work_mohm) <<< R_FRAC)) begin
               nxt_st.sar = trial;                      // [R14]
            end
            if (st_ff.bit_idx == 5'h00) begin
               nxt_st.phase = PH_TRIM;
            end else begin
               nxt_st.bit_idx = st_ff.bit_idx - 5'h01;
            end
         end
         PH_TRIM: begin
            nxt_st.code    = st_ff.work_code;           // [R17]
            nxt_st.ohms    = st_ff.work_mohm;           // [R12]
            nxt_st.celsius = DATA_W'(trimmed);          // [R13]
            nxt_st.phase   = PH_IDLE;
         end
      endcase
      if (probe_connection_query) begin
         nxt_st.ans_valid = 1'b1;
         nxt_st.ans_data  = DATA_W'(st_ff.code);
      end else if (probe_ohms_query) begin
         nxt_st.ans_valid = 1'b1;
         nxt_st.ans_data  = st_ff.ohms;                 // [R12]
      end else if (probe_celsius_query) begin
         nxt_st.ans_valid = 1'b1;
         nxt_st.ans_data  = st_ff.celsius;              // [R13]
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff         <= '0;
         st_ff.phase   <= PH_IDLE;
         st_ff.code    <= CODE_NO_PROBE;
         st_ff.ohms    <= SENTINEL_OHMS;
         st_ff.celsius <= SENTINEL_CELSIUS;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign connection_code    = st_ff.code;
   assign probe_ohms         = st_ff.ohms;
   assign probe_celsius      = st_ff.celsius;
   assign probe_fault_status = st_ff.code < 0;          // [R04]
   assign answer_valid       = st_ff.ans_valid;
   assign answer_data        = st_ff.ans_data;

endmodule : resistance_thermometer_readout

// ---- verification/probe_readout_properties.sv ----
// concurrent checks on the probe readout ports
`timescale 1ns/1ps
module probe_readout_properties
   import probe_readout_pkg::*;
(
   input wire logic                     mclk,
   input wire logic                     rst_b,
   input wire logic                     sample_valid,
   input wire logic                     probe_connection_query,
   input wire logic                     probe_ohms_query,
   input wire logic                     probe_celsius_query,
   input wire logic signed [CODE_W-1:0] connection_code,
   input wire logic signed [DATA_W-1:0] probe_ohms,
   input wire logic signed [DATA_W-1:0] probe_celsius,
   input wire logic                     probe_fault_status,
   input wire logic                     answer_valid,
   input wire logic signed [DATA_W-1:0] answer_data
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence ask_code; probe_connection_query; endsequence
   sequence ask_ohms; probe_ohms_query && !probe_connection_query; endsequence
   sequence ask_temp;
      probe_celsius_query && !probe_ohms_query && !probe_connection_query;
   endsequence
   sequence quiet;
      !probe_connection_query && !probe_ohms_query && !probe_celsius_query;
   endsequence
   a_status_follows_code:
      assert property (probe_fault_status == (connection_code < 0))
      else $error("fault status disagrees with code");
   a_code_in_table:
      assert property (connection_code inside {[-5:-1], [1:4]})
      else $error("connection code outside table");
   a_ohms_fault_sentinel:
      assert property (connection_code < 0 |-> probe_ohms == SENTINEL_OHMS)
      else $error("ohms not sentinel on fault");
   a_temp_fault_sentinel:
      assert property (connection_code < 0
         |-> probe_celsius == SENTINEL_CELSIUS)
      else $error("celsius not sentinel on fault");
   a_code_answer_next:
      assert property (ask_code |=> answer_valid
         && answer_data == DATA_W'($past(connection_code)))
      else $error("code answer wrong");
   a_ohms_answer_next:
      assert property (ask_ohms |=> answer_valid
         && answer_data == $past(probe_ohms))
      else $error("ohms answer wrong");
   a_temp_answer_next:
      assert property (ask_temp |=> answer_valid
         && answer_data == $past(probe_celsius))
      else $error("celsius answer wrong");
   a_no_idle_answer:
      assert property (quiet |=> !answer_valid)
      else $error("answer without query");
   a_commit_after_sample:
      assert property (!$stable({connection_code, probe_ohms, probe_celsius})
         |-> $past(sample_valid, 2) || $past(sample_valid, 21))
      else $error("results changed off the commit cycle");
endmodule : probe_readout_properties

bind resistance_thermometer_readout probe_readout_properties
   u_probe_readout_properties (.mclk, .rst_b, .sample_valid,
   .probe_connection_query, .probe_ohms_query, .probe_celsius_query,
   .connection_code, .probe_ohms, .probe_celsius, .probe_fault_status,
   .answer_valid, .answer_data);

// ---- verification/probe_model.sv ----
// passive probe wired in one of several schemes, lead drops in milliohm
`timescale 1ns/1ps
module probe_model
   import probe_readout_pkg::*;
(
   input  wire logic [2:0]               scheme,
   input  wire logic signed [VOLT_W-1:0] r_mohm,
   input  wire logic signed [VOLT_W-1:0] lead,
   input  wire logic signed [VOLT_W-1:0] base,
   output logic signed [VOLT_W-1:0]      excitation_high_terminal_v,
   output logic signed [VOLT_W-1:0]      sense_high_terminal_v,
   output logic signed [VOLT_W-1:0]      sense_low_terminal_v,
   output logic signed [VOLT_W-1:0]      excitation_low_terminal_v
);
   // open terminal rests at the pull-up level
   localparam logic signed [VOLT_W-1:0] FLOAT_V = 24'h7FFFFF;
   always_comb begin
      excitation_low_terminal_v  = base;
      sense_low_terminal_v       = base + lead;
      sense_high_terminal_v      = base + lead + r_mohm;
      excitation_high_terminal_v = base + lead + lead + r_mohm;
      if (scheme == 3'h5) begin
         sense_low_terminal_v  = base + lead + r_mohm;
         sense_high_terminal_v = base + lead;
      end
      if (scheme inside {3'h0, 3'h1, 3'h3}) sense_high_terminal_v = FLOAT_V;
      if (scheme inside {3'h0, 3'h1, 3'h2}) sense_low_terminal_v = FLOAT_V;
      if (scheme == 3'h0) excitation_high_terminal_v = FLOAT_V;
   end
endmodule : probe_model

// ---- verification/tb.sv ----
// self-checking bench for the probe readout
`timescale 1ns/1ps
module tb;
   import probe_readout_pkg::*;
   logic mclk, rst_b, sample_valid, adc_fault;
   logic probe_fault_status, answer_valid;
   logic probe_connection_query, probe_ohms_query, probe_celsius_query;
   logic signed [VOLT_W-1:0] excitation_high_terminal_v, sense_high_terminal_v;
   logic signed [VOLT_W-1:0] sense_low_terminal_v, excitation_low_terminal_v;
   logic signed [VOLT_W-1:0] r_mohm, lead, base;
   logic signed [DATA_W-1:0] temperature_gain_trim, temperature_offset_trim;
   logic signed [DATA_W-1:0] probe_ohms, probe_celsius, answer_data;
   logic signed [CODE_W-1:0] connection_code;
   logic [2:0]               scheme;
   int                       num_errors, total_checks, cycles;
   probe_model u_probe_model (.scheme, .r_mohm, .lead, .base,
      .excitation_high_terminal_v, .sense_high_terminal_v,
      .sense_low_terminal_v, .excitation_low_terminal_v);
   resistance_thermometer_readout u_resistance_thermometer_readout (
      .mclk, .rst_b, .sample_valid, .adc_fault, .excitation_high_terminal_v,
      .sense_high_terminal_v, .sense_low_terminal_v,
      .excitation_low_terminal_v, .temperature_gain_trim,
      .temperature_offset_trim, .probe_connection_query, .probe_ohms_query,
      .probe_celsius_query, .connection_code, .probe_ohms, .probe_celsius,
      .probe_fault_status, .answer_valid, .answer_data);
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic chk(input logic [DATA_W-1:0] got,
                      input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ask(input logic [2:0] k, input logic [DATA_W-1:0] exp);
      @(negedge mclk);
      {probe_connection_query, probe_ohms_query, probe_celsius_query} = k;
      @(negedge mclk);
      {probe_connection_query, probe_ohms_query, probe_celsius_query} = 3'h0;
      chk(DATA_W'(answer_valid), 32'h00000001);
      chk(answer_data, exp);
   endtask : ask
   task automatic measure(input logic [2:0] s,
                          input logic signed [VOLT_W-1:0] r, l, b,
                          input logic f);
      @(negedge mclk);
      {scheme, r_mohm, lead, base} = {s, r, l, b};
      {adc_fault, sample_valid} = {f, 1'b1};
      @(negedge mclk);
      sample_valid = 1'b0;
   endtask : measure
   task automatic check_outputs(input logic signed [CODE_W-1:0] c,
                                input logic signed [DATA_W-1:0] o, t);
      if (c < 0) {o, t} = {SENTINEL_OHMS, SENTINEL_CELSIUS};
      chk(DATA_W'(connection_code), DATA_W'(c));
      chk(probe_ohms, o);
      chk(probe_celsius, t);
      chk(DATA_W'(probe_fault_status), DATA_W'(c < 0));
      ask(3'h4, DATA_W'(c));
      ask(3'h2, o);
      ask(3'h1, t);
      $display("test with code %0d done", c);
   endtask : check_outputs
   task automatic run(input logic [2:0] s, input logic signed [VOLT_W-1:0] r,
      l, b, input logic f, input logic signed [CODE_W-1:0] c,
      input logic signed [DATA_W-1:0] o, t);
      measure(s, r, l, b, f);
      repeat (22) @(negedge mclk);
      check_outputs(c, o, t);
   endtask : run
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      {rst_b, sample_valid, adc_fault, scheme} = 6'h00;
      {probe_connection_query, probe_ohms_query, probe_celsius_query} = 3'h0;
      {r_mohm, lead, base} = 72'h0;
      temperature_gain_trim   = 32'h00010000;
      temperature_offset_trim = 32'h00000000;
      repeat (16) @(posedge mclk);
      @(negedge mclk) rst_b = 1'b1;
      check_outputs(CODE_NO_PROBE, 32'h0, 32'h0);
      run(3'h4, 24'h0186A0, 24'h00012C, 24'h0003E8, 1'b0, CODE_FOUR_WIRE,
          32'h000186A0, 32'h00000000);
      run(3'h1, 24'h0186A0, 24'h0000FA, 24'h0003E8, 1'b0, CODE_TWO_WIRE,
          32'h000186A0, 32'h00000000);
      run(3'h2, 24'h01869F, 24'h0002BC, 24'h000064, 1'b0, CODE_THREE_HI,
          32'h0001869F, 32'hFFFFFFFF);
      run(3'h3, 24'h0186A0, 24'h000384, 24'h000064, 1'b0, CODE_THREE_LO,
          32'h000186A0, 32'h00000000);
      run(3'h0, 24'h0186A0, 24'h000064, 24'h000064, 1'b0, CODE_NO_PROBE,
          32'h0, 32'h0);
      run(3'h5, 24'h0186A0, 24'h000064, 24'h000064, 1'b0, CODE_SWAPPED,
          32'h0, 32'h0);
      run(3'h1, 24'h000064, 24'h000000, 24'h000064, 1'b0, CODE_NEG_OHMS,
          32'h0, 32'h0);
      run(3'h4, 24'h0186A0, 24'h000064, 24'hFFFC18, 1'b0, CODE_NEG_VOLT,
          32'h0, 32'h0);
      run(3'h4, 24'h0186A0, 24'h000064, 24'h000064, 1'b1, CODE_ADC_FAIL,
          32'h0, 32'h0);
      // 60.256 ohm lies just above the curve point for -100 degC
      run(3'h4, 24'h00EB60, 24'h000064, 24'h000064, 1'b0, CODE_FOUR_WIRE,
          32'h0000EB60, 32'hFFFF9C00);
      temperature_gain_trim   = 32'h00020000;
      temperature_offset_trim = 32'h00000100;
      // 138.506 ohm solves to +100 degC, then 2x plus 1 degC
      measure(3'h4, 24'h021D0A, 24'h000064, 24'h000064, 1'b0);
      repeat (3) @(negedge mclk);
      // this sample lands while busy and must be dropped
      run(3'h4, 24'h0186A0, 24'h000064, 24'h000064, 1'b1, CODE_FOUR_WIRE,
          32'h00021D0A, 32'h0000C900);
      ask(3'h7, DATA_W'(CODE_FOUR_WIRE));
      test_done();
   end
endmodule : tb
